// [design/reset_and_low_voltage_supervisor.sv]
// Purpose: merge reset sources, supervise supply, detect low supply
// Assumes: 25 MHz clock; comparators and pin are asynchronous
// Notes: threshold of reset comparator is fixed outside by hardware
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module reset_and_low_voltage_supervisor
(
    // clock and power-on reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // option and comparators
    input wire logic i_use_internal_reset,
    input wire logic i_supply_drop_reset_circuit,
    input wire logic i_supply_drop_detector,
    // reset pin, open drain
    input wire logic i_reset_pin_active_low,
    output logic o_reset_pin_line_out,
    output logic o_reset_pin_line_oe,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // outputs
    output logic [1:0] o_detect_level_sel,
    output logic o_detect_enable,
    output logic o_sys_reset_n,
    output logic o_irq
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic pin_low_s;
    logic lvr_low_s;
    logic lvd_low_s;
    logic pin_n_s;
    logic use_internal_s;

    // pin goes straight into the first flop; an inverter ahead of the
    // synchroniser would be logic reading an unsettled level
    level_sync u_pin_sync
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_reset_pin_active_low),
        .o_sync(pin_n_s)
    );
    // synchroniser clears to zero, so the pin reads low until it settles
    assign pin_low_s = !pin_n_s;

    // option strap comes from outside this clock, synchronised like a pin
    level_sync u_opt_sync
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_use_internal_reset),
        .o_sync(use_internal_s)
    );

    level_sync u_lvr_sync
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_supply_drop_reset_circuit),
        .o_sync(lvr_low_s)
    );

    level_sync u_lvd_sync
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_supply_drop_detector),
        .o_sync(lvd_low_s)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] det_ctrl_r;
    logic [7:0] timer_ctrl_r;
    logic [1:0] irq_status_r;
    logic [1:0] irq_enable_r;
    logic [2:0] cause_r;
    logic internal_rst;
    logic wdt_enable;
    logic wdt_overflow;
    logic wdt_kick;
    logic supply_low_indicator;
    logic det_low_prev_r;
    logic supply_reset_req;
    logic wr_det;
    logic wr_clr;
    logic wr_timer;
    logic wr_irq_en;
    logic reset_event;

    assign wr_det = i_wr && (i_addr == supervisor_pkg::ADDR_DETECT_CTRL);
    assign wr_timer = i_wr && (i_addr == supervisor_pkg::ADDR_TIMER_CTRL);
    assign wr_irq_en = i_wr && (i_addr == supervisor_pkg::ADDR_IRQ_ENABLE);
    assign wr_clr = i_wr && (i_addr == supervisor_pkg::ADDR_IRQ_CLEAR);
    assign wdt_kick = i_wr && (i_addr == supervisor_pkg::ADDR_WDT_KICK);

    // option enables the supply comparator as reset source; the pin is always one
    assign supply_reset_req =
        use_internal_s ? lvr_low_s : 1'b0;

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    // disable pattern in the upper nibble stops watchdog resets
    assign wdt_enable = timer_ctrl_r[7:4] != supervisor_pkg::WDT_DISABLE_CODE;

    watchdog_counter u_wdt
    (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n && !internal_rst),
        .i_enable(wdt_enable),
        .i_kick(wdt_kick),
        .o_overflow(wdt_overflow)
    );

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    supervisor_pkg::rst_state_t state_r;
    logic [7:0] pulse_cnt_r;

    // a source seen while running starts the pin pulse
    assign reset_event = (state_r == supervisor_pkg::ST_RUN)
        && (supply_reset_req || pin_low_s || wdt_overflow);

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            state_r <= supervisor_pkg::ST_HOLD;
        else
        begin
            unique case (state_r)
                supervisor_pkg::ST_HOLD:
                begin
                    // leave only once pin high and, with the option set, supply good
                    if (!supply_reset_req && !pin_low_s)
                        state_r <= supervisor_pkg::ST_RUN;
                end
                supervisor_pkg::ST_RUN:
                begin
                    if (reset_event)
                        state_r <= supervisor_pkg::ST_PULSE;
                end
                supervisor_pkg::ST_PULSE:
                begin
                    // pulse lets the pin be seen low externally
                    if (pulse_cnt_r ==
                        8'(supervisor_pkg::RST_PULSE_CYCLES - 1))
                        state_r <= supervisor_pkg::ST_HOLD;
                end
                default:
                    state_r <= supervisor_pkg::ST_HOLD;
            endcase
        end
    end

    // pulse length counter, runs only while the pin is pulled
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || state_r != supervisor_pkg::ST_PULSE)
            pulse_cnt_r <= 8'h0;
        else
            pulse_cnt_r <= pulse_cnt_r + 8'h1;
    end

    assign internal_rst = state_r != supervisor_pkg::ST_RUN;

    // ------------------------------------------------------------
    // reset cause
    // ------------------------------------------------------------
    // kept across internal resets so software can read it afterwards
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            cause_r <= 3'h0;
        else if (reset_event)
            cause_r <= {supply_reset_req, wdt_overflow, pin_low_s};
    end

    // pin driven low only for the pulse, else it would hold itself
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            o_reset_pin_line_oe <= 1'b0;
            o_reset_pin_line_out <= 1'b0;
            o_sys_reset_n <= 1'b0;
        end
        else
        begin
            o_reset_pin_line_oe <= state_r == supervisor_pkg::ST_PULSE;
            o_reset_pin_line_out <= 1'b0;
            o_sys_reset_n <= !internal_rst;
        end
    end

    // ------------------------------------------------------------
    // control registers, restored on any internal reset
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || internal_rst)
        begin
            det_ctrl_r <= supervisor_pkg::DET_CTRL_RST;
            timer_ctrl_r <= supervisor_pkg::TIMER_CTRL_RST;
            irq_enable_r <= supervisor_pkg::IRQ_EN_RST;
        end
        else if (i_wr)
        begin
            if (wr_det)
                det_ctrl_r <= i_wdata;
            if (wr_timer)
                timer_ctrl_r <= i_wdata;
            if (wr_irq_en)
                irq_enable_r <= i_wdata[1:0];
        end
    end

    // detector output gated by enable bit
    assign o_detect_enable = det_ctrl_r[supervisor_pkg::DET_EN_BIT];
    assign supply_low_indicator = o_detect_enable && lvd_low_s;
    assign o_detect_level_sel =
        det_ctrl_r[supervisor_pkg::DET_LVL_LO +: 2];

    // ------------------------------------------------------------
    // interrupts: set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || internal_rst)
        begin
            irq_status_r <= 2'h0;
            det_low_prev_r <= 1'b0;
        end
        else
        begin
            det_low_prev_r <= supply_low_indicator;
            irq_status_r[supervisor_pkg::IRQ_DET_BIT] <=
                (supply_low_indicator && !det_low_prev_r)
                || (irq_status_r[supervisor_pkg::IRQ_DET_BIT]
                    && !(wr_clr && i_wdata[supervisor_pkg::IRQ_DET_BIT]));
            // spare status bit, kept clear
            irq_status_r[supervisor_pkg::IRQ_CLR_BIT] <= 1'b0;
        end
    end

    // level output follows status and enable one cycle later
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || internal_rst)
            o_irq <= 1'b0;
        else
            o_irq <= |(irq_status_r & irq_enable_r);
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            o_rdata <= 8'h0;
        else if (i_rd)
        begin
            unique case (i_addr)
                supervisor_pkg::ADDR_DETECT_CTRL:
                    o_rdata <= {det_ctrl_r[7:6], supply_low_indicator,
                        det_ctrl_r[4:0]};
                supervisor_pkg::ADDR_TIMER_CTRL:
                    o_rdata <= timer_ctrl_r;
                supervisor_pkg::ADDR_IRQ_STATUS:
                    o_rdata <= {6'h0, irq_status_r};
                supervisor_pkg::ADDR_IRQ_ENABLE:
                    o_rdata <= {6'h0, irq_enable_r};
                supervisor_pkg::ADDR_RESET_CAUSE:
                    o_rdata <= {5'h0, cause_r};
                default:
                    o_rdata <= 8'h0;
            endcase
        end
        else
            o_rdata <= 8'h0;
    end
endmodule : reset_and_low_voltage_supervisor

// [design/supervisor_pkg.sv]
// Purpose: shared constants for the reset and supply supervisor
// Assumes: 25 MHz system clock, 8-bit register port
// Notes: offsets are word indices on the plain register port
package supervisor_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_DETECT_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TIMER_CTRL = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
    localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;
    localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h4;
    localparam logic [3:0] ADDR_RESET_CAUSE = 4'h5;
    localparam logic [3:0] ADDR_WDT_KICK = 4'h6;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DET_EN_BIT = 7;
    localparam int DET_FLAG_BIT = 5;
    localparam int DET_LVL_LO = 0;
    localparam logic [3:0] WDT_DISABLE_CODE = 4'ha;
    localparam int IRQ_DET_BIT = 0;
    localparam int IRQ_CLR_BIT = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DET_CTRL_RST = 8'h00;
    localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
    localparam logic [1:0] IRQ_EN_RST = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int WDT_TIMEOUT_US = 1000;
    localparam int WDT_CYCLES = (CLK_HZ / 1000000) * WDT_TIMEOUT_US;
    localparam int RST_PULSE_NS = 400;
    localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + 39) / 40;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_RUN = 2'b01,
        ST_PULSE = 2'b10
    } rst_state_t;

endpackage : supervisor_pkg

// [design/level_sync.sv]
// Purpose: two-stage synchroniser for one asynchronous level
// Assumes: destination clock i_sys_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module level_sync
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // level
    input wire logic i_async,
    output logic o_sync
);
    logic meta_r;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            meta_r <= 1'b0;
            o_sync <= 1'b0;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule : level_sync

// [design/watchdog_counter.sv]
// Purpose: watchdog counter with overflow pulse
// Assumes: kick and enable from same clock
// Notes: overflow is a one-cycle pulse, counter restarts after it
`timescale 1ns/10ps
module watchdog_counter
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // control
    input wire logic i_enable,
    input wire logic i_kick,
    output logic o_overflow
);
    logic [31:0] count_r;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n || !i_enable || i_kick)
        begin
            count_r <= 32'h0;
            o_overflow <= 1'b0;
        end
        else if (count_r == 32'(supervisor_pkg::WDT_CYCLES - 1))
        begin
            count_r <= 32'h0;
            o_overflow <= 1'b1;
        end
        else
        begin
            count_r <= count_r + 32'h1;
            o_overflow <= 1'b0;
        end
    end
endmodule : watchdog_counter

// [tb/supervisor_checker_properties.sv]
// Purpose: port-level checks of the reset and supply supervisor
// Assumes: one clock domain, i_reset_n synchronous active low
// Notes: bound to the top module from the testbench
`timescale 1ns/10ps
module supervisor_checker
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // option, comparators, pin
    input wire logic i_use_internal_reset,
    input wire logic i_supply_drop_reset_circuit,
    input wire logic i_supply_drop_detector,
    input wire logic i_reset_pin_active_low,
    input wire logic o_reset_pin_line_out,
    input wire logic o_reset_pin_line_oe,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // outputs
    input wire logic [1:0] o_detect_level_sel,
    input wire logic o_detect_enable,
    input wire logic o_sys_reset_n,
    input wire logic o_irq
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    a_pin_open_drain: assert property (
        !o_reset_pin_line_out) else $error("pin driven high");
    a_pin_pull_reset: assert property (
        o_reset_pin_line_oe |-> !o_sys_reset_n) else $error("pin pulled in run");
    a_pin_sync_delay: assert property (
        $fell(i_reset_pin_active_low) && o_sys_reset_n |=> o_sys_reset_n)
        else $error("pin acted unsynchronised");
    a_pin_low_resets: assert property (
        $fell(i_reset_pin_active_low) && o_sys_reset_n
        |-> ##[1:4] !o_sys_reset_n) else $error("pin reset missed");
    a_supply_holds_reset: assert property (
        (i_use_internal_reset && i_supply_drop_reset_circuit)[*5]
        |-> !o_sys_reset_n) else $error("reset not held on low supply");
    a_release_when_clean: assert property (
        $rose(o_sys_reset_n) |-> i_reset_pin_active_low &&
        !(i_use_internal_reset && $past(i_supply_drop_reset_circuit, 2)))
        else $error("release while source active");
    a_rdata_idle_zero: assert property (
        !$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
    a_ctrl_read_back: assert property (
        i_rd && i_addr == supervisor_pkg::ADDR_DETECT_CTRL && o_sys_reset_n
        |=> o_rdata[7] == $past(o_detect_enable) &&
        o_rdata[1:0] == $past(o_detect_level_sel))
        else $error("control read back wrong");
    a_flag_when_off: assert property (
        i_rd && i_addr == supervisor_pkg::ADDR_DETECT_CTRL &&
        !o_detect_enable |=> !o_rdata[5]) else $error("flag while disabled");
    a_regs_cleared: assert property (
        (!o_sys_reset_n)[*2] |-> !o_detect_enable &&
        o_detect_level_sel == 2'h0 && !o_irq) else $error("regs not cleared");
endmodule : supervisor_checker

// [tb/supply_partner.sv]
// Purpose: board reset line and supply comparators
// Assumes: reset line has a pull-up
// Notes: comparator thresholds are fixed, only the outcome is modelled
`timescale 1ns/10ps
module supply_partner
(
    // board controls
    input wire logic i_board_hold,
    input wire logic i_rst_low,
    input wire logic i_det_low,
    // device pin drive
    input wire logic i_pin_out,
    input wire logic i_pin_oe,
    // lines to device
    output logic o_pin,
    output logic o_rst_cmp,
    output logic o_det_cmp
);
    // released line floats back high through the pull-up
    assign o_pin = (i_pin_oe && !i_pin_out) || i_board_hold ? 1'b0 : 1'b1;
    assign o_rst_cmp = i_rst_low;
    assign o_det_cmp = i_det_low;
endmodule : supply_partner

// [tb/test_reset_and_low_voltage_supervisor.sv]
// Purpose: self-checking bench for the reset and supply supervisor
// Assumes: 25 MHz clock, package register offsets
// Notes: watchdog runs at full length, about 72000 cycles in total
`timescale 1ns/10ps
module test_reset_and_low_voltage_supervisor;
    logic i_sys_clk, i_reset_n, i_use_internal_reset, i_wr, i_rd, o_irq;
    logic board_hold, rst_low, det_low, o_detect_enable, o_sys_reset_n;
    logic i_supply_drop_reset_circuit, i_supply_drop_detector;
    logic i_reset_pin_active_low, o_reset_pin_line_out, o_reset_pin_line_oe;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    logic [1:0] o_detect_level_sel;
    int num_errors = 0;
    int n_tests = 0;

    reset_and_low_voltage_supervisor DUT (.i_sys_clk, .i_reset_n,
        .i_use_internal_reset, .i_supply_drop_reset_circuit,
        .i_supply_drop_detector, .i_reset_pin_active_low,
        .o_reset_pin_line_out, .o_reset_pin_line_oe, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .o_detect_level_sel, .o_detect_enable,
        .o_sys_reset_n, .o_irq);
    supply_partner board (.i_board_hold(board_hold), .i_rst_low(rst_low),
        .i_det_low(det_low), .i_pin_out(o_reset_pin_line_out),
        .i_pin_oe(o_reset_pin_line_oe), .o_pin(i_reset_pin_active_low),
        .o_rst_cmp(i_supply_drop_reset_circuit),
        .o_det_cmp(i_supply_drop_detector));

    initial
    begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        check("rdata", exp, o_rdata);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : idle

    // bounded wait; a limit of zero is a plain check
    task automatic wait_sys(input logic lvl, input int lim);
        int k;
        k = 0;
        @(negedge i_sys_clk);
        while (o_sys_reset_n !== lvl && k < lim)
        begin
            @(negedge i_sys_clk);
            k++;
        end
        check("sys_reset_n", {7'h00, lvl}, {7'h00, o_sys_reset_n});
    endtask : wait_sys

    task automatic irq_is(input logic v);
        @(negedge i_sys_clk);
        check("irq", {7'h00, v}, {7'h00, o_irq});
    endtask : irq_is

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        i_reset_n = 1'b0;
        i_use_internal_reset = 1'b1;
        {i_wr, i_rd, board_hold, rst_low, det_low} = 5'h00;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        idle(8);
        i_reset_n <= 1'b1;
        wait_sys(1'b1, 50);
        wr(supervisor_pkg::ADDR_TIMER_CTRL, 8'ha0);
        rd(supervisor_pkg::ADDR_DETECT_CTRL, 8'h00);
        rd(supervisor_pkg::ADDR_TIMER_CTRL, 8'ha0);
        rd(supervisor_pkg::ADDR_IRQ_ENABLE, 8'h00);
        rd(4'hf, 8'h00);
        for (int l = 0; l < 4; l++)
        begin
            wr(supervisor_pkg::ADDR_DETECT_CTRL, 8'h80 | 8'(l));
            @(negedge i_sys_clk);
            check("level", 8'(l), {6'h00, o_detect_level_sel});
            check("enable", 8'h01, {7'h00, o_detect_enable});
        end
        wr(supervisor_pkg::ADDR_IRQ_ENABLE, 8'h01);
        @(posedge i_sys_clk) det_low <= 1'b1;
        idle(6);
        irq_is(1'b1);
        rd(supervisor_pkg::ADDR_DETECT_CTRL, 8'ha3);
        rd(supervisor_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr(supervisor_pkg::ADDR_IRQ_ENABLE, 8'h00);
        idle(1);
        irq_is(1'b0);
        @(posedge i_sys_clk) det_low <= 1'b0;
        idle(6);
        rd(supervisor_pkg::ADDR_DETECT_CTRL, 8'h83);
        rd(supervisor_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr(supervisor_pkg::ADDR_IRQ_CLEAR, 8'h01);
        rd(supervisor_pkg::ADDR_IRQ_STATUS, 8'h00);
        wr(supervisor_pkg::ADDR_IRQ_ENABLE, 8'h01);
        wr(supervisor_pkg::ADDR_DETECT_CTRL, 8'h02);
        @(posedge i_sys_clk) det_low <= 1'b1;
        idle(6);
        irq_is(1'b0);
        rd(supervisor_pkg::ADDR_DETECT_CTRL, 8'h02);
        @(posedge i_sys_clk) det_low <= 1'b0;
        // board pulls the reset pin
        @(posedge i_sys_clk) board_hold <= 1'b1;
        wait_sys(1'b0, 5);
        check("pin_oe", 8'h01, {7'h00, o_reset_pin_line_oe});
        idle(20);
        board_hold <= 1'b0;
        wait_sys(1'b1, 40);
        rd(supervisor_pkg::ADDR_DETECT_CTRL, 8'h00);
        rd(supervisor_pkg::ADDR_RESET_CAUSE, 8'h01);
        // supply comparator, with and without the option
        @(posedge i_sys_clk) rst_low <= 1'b1;
        wait_sys(1'b0, 5);
        idle(30);
        wait_sys(1'b0, 0);
        @(posedge i_sys_clk) rst_low <= 1'b0;
        wait_sys(1'b1, 40);
        rd(supervisor_pkg::ADDR_RESET_CAUSE, 8'h04);
        @(posedge i_sys_clk) i_use_internal_reset <= 1'b0;
        idle(2);
        rst_low <= 1'b1;
        idle(30);
        wait_sys(1'b1, 0);
        // strap back only once the comparator has settled inside
        @(posedge i_sys_clk) rst_low <= 1'b0;
        idle(4);
        i_use_internal_reset <= 1'b1;
        // watchdog off, then on with one kick
        wr(supervisor_pkg::ADDR_TIMER_CTRL, 8'ha0);
        idle(26000);
        wait_sys(1'b1, 0);
        rd(supervisor_pkg::ADDR_RESET_CAUSE, 8'h04);
        wr(supervisor_pkg::ADDR_TIMER_CTRL, 8'h00);
        idle(20000);
        wr(supervisor_pkg::ADDR_WDT_KICK, 8'h00);
        idle(20000);
        wait_sys(1'b1, 0);
        wait_sys(1'b0, 6000);
        wait_sys(1'b1, 40);
        rd(supervisor_pkg::ADDR_RESET_CAUSE, 8'h02);
        report_and_stop();
    end

    initial
    begin
        #4000000;
        num_errors++;
        report_and_stop();
    end
endmodule : test_reset_and_low_voltage_supervisor

bind reset_and_low_voltage_supervisor supervisor_checker chk (.i_sys_clk,
    .i_reset_n, .i_use_internal_reset, .i_supply_drop_reset_circuit,
    .i_supply_drop_detector, .i_reset_pin_active_low, .o_reset_pin_line_out,
    .o_reset_pin_line_oe, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_detect_level_sel, .o_detect_enable, .o_sys_reset_n, .o_irq);
